// [design/sfd_pkg.sv]
// Purpose: shared types and constants of the serial flash opcode decoder
// Assumes: opcodes arrive msb first on the first data line
// Notes: dummy counts are plain defaults, the true latency lives elsewhere
package sfd_pkg;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_STATUS_CONFIG_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_QUICK_READ = 8'h0B;
    localparam logic [7:0] OP_QUICK_READ_LONG = 8'h0C;
    localparam logic [7:0] OP_DTR_QUICK_READ = 8'h0D;
    localparam logic [7:0] OP_DTR_QUICK_READ_LONG = 8'h0E;
    localparam logic [7:0] OP_PAGE_WRITE_LONG = 8'h12;
    localparam logic [7:0] OP_ARRAY_READ_LONG = 8'h13;
    localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
    localparam logic [7:0] OP_SMALL_WIPE_LONG = 8'h21;
    localparam logic [7:0] OP_FAIL_CLEAR = 8'h30;
    localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
    localparam logic [7:0] OP_QUAD_PAGE_WRITE_LONG = 8'h34;
    localparam logic [7:0] OP_QUAD_PAGE_WRITE_ALT = 8'h38;
    localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
    localparam logic [7:0] OP_DUAL_OUT_READ_LONG = 8'h3C;
    localparam logic [7:0] OP_LEARN_READBACK = 8'h41;
    localparam logic [7:0] OP_LEARN_NV_PROGRAM = 8'h43;
    localparam logic [7:0] OP_LEARN_VOLATILE_WRITE = 8'h4A;
    localparam logic [7:0] OP_WHOLE_WIPE = 8'h60;
    localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
    localparam logic [7:0] OP_QUAD_OUT_READ_LONG = 8'h6C;
    localparam logic [7:0] OP_IDENTITY_QUERY = 8'h9F;
    localparam logic [7:0] OP_MULTI_IO_MODE = 8'hA3;
    localparam logic [7:0] OP_SIGNATURE_QUERY = 8'hAB;
    localparam logic [7:0] OP_BANK_ACCESS = 8'hB9;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OP_DUAL_IO_READ_LONG = 8'hBC;
    localparam logic [7:0] OP_DTR_DUAL_IO_READ = 8'hBD;
    localparam logic [7:0] OP_DTR_DUAL_IO_READ_LONG = 8'hBE;
    localparam logic [7:0] OP_WHOLE_WIPE_ALT = 8'hC7;
    localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
    localparam logic [7:0] OP_BLOCK_WIPE_LONG = 8'hDC;
    localparam logic [7:0] OP_RESERVED_E5 = 8'hE5;
    localparam logic [7:0] OP_RESERVED_E6 = 8'hE6;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] OP_QUAD_IO_READ_LONG = 8'hEC;
    localparam logic [7:0] OP_DTR_QUAD_IO_READ = 8'hED;
    localparam logic [7:0] OP_DTR_QUAD_IO_READ_LONG = 8'hEE;
    localparam logic [7:0] OP_MODE_BITS_CLEAR = 8'hFF;

    // ----------------------------------------
    // clock limits in MHz, widths and lanes
    // ----------------------------------------
    localparam logic [7:0] MHZ_SLOW = 8'h32;
    localparam logic [7:0] MHZ_DTR = 8'h50;
    localparam logic [7:0] MHZ_MULTI = 8'h68;
    localparam logic [7:0] MHZ_FULL = 8'h85;
    localparam logic [2:0] ADDR_NONE = 3'h0;
    localparam logic [2:0] ADDR_SHORT = 3'h3;
    localparam logic [2:0] ADDR_LONG = 3'h4;
    localparam logic [2:0] LANES_ONE = 3'h1;
    localparam logic [2:0] LANES_TWO = 3'h2;
    localparam logic [2:0] LANES_FOUR = 3'h4;
    localparam logic [3:0] DUMMY_NONE = 4'h0;
    localparam logic [3:0] DUMMY_SDR = 4'h8;
    localparam logic [3:0] DUMMY_DTR = 4'h6;
    localparam logic [3:0] DUMMY_IO = 4'h4;
    localparam logic [3:0] OP_BITS = 4'h8;
    localparam logic [3:0] OP_LAST_BIT = 4'h7;

    // ----------------------------------------
    // command kinds and decoded record
    // ----------------------------------------
    typedef enum logic [4:0] {
        SFD_CMD_NONE, SFD_CMD_REG_WRITE, SFD_CMD_READ, SFD_CMD_QUICK_READ,
        SFD_CMD_DTR_QUICK_READ, SFD_CMD_PAGE_WRITE, SFD_CMD_QUAD_PAGE_WRITE,
        SFD_CMD_DUAL_OUT_READ, SFD_CMD_QUAD_OUT_READ, SFD_CMD_DUAL_IO_READ,
        SFD_CMD_DTR_DUAL_IO_READ, SFD_CMD_QUAD_IO_READ, SFD_CMD_DTR_QUAD_IO_READ,
        SFD_CMD_BLOCK_WIPE, SFD_CMD_SMALL_WIPE, SFD_CMD_WHOLE_WIPE,
        SFD_CMD_FAIL_CLEAR, SFD_CMD_IDENTITY, SFD_CMD_SIGNATURE,
        SFD_CMD_BANK_ACCESS, SFD_CMD_LEARN_WRITE, SFD_CMD_LEARN_PROGRAM,
        SFD_CMD_LEARN_READ, SFD_CMD_MODE_CLEAR, SFD_CMD_OTHER
    } sfd_cmd_e;

    typedef struct packed {
        sfd_cmd_e cmd;
        logic [7:0] opcode;
        logic [2:0] addrBytes;
        logic [2:0] addrLanes;
        logic [3:0] dummy;
        logic [2:0] dataLanes;
        logic dtr;
        logic [7:0] maxMhz;
    } sfd_cmd_info_s;

    typedef enum logic [1:0] {
        SFD_ST_IDLE = 2'b00,
        SFD_ST_WAIT_OP = 2'b01,
        SFD_ST_ACTIVE = 2'b11,
        SFD_ST_SKIP = 2'b10
    } sfd_state_e;

endpackage

// [design/sfd_link_rx.sv]
// Purpose: opcode shifter on the serial clock
// Assumes: serial clock mode 0 or 3, data sampled on the rising edge
// Notes: chip select high clears the bit count without a clock edge
`timescale 1ns/1ns
`default_nettype none
module sfd_link_rx (
    // link pins
    input wire logic spiClk,
    input wire logic csN,
    input wire logic si,
    // reset from the system side, held constant
    input wire logic linkRst,
    // to the system side
    output logic [7:0] opcode,
    output logic opToggle
);

    logic [3:0] bitCount;
    logic [6:0] shiftReg;
    wire lastBit = (bitCount == sfd_pkg::OP_LAST_BIT);
    wire counting = (bitCount < sfd_pkg::OP_BITS);

    // ----------------------------------------
    // bit counter, ended by the frame itself
    // ----------------------------------------
    always_ff @(posedge spiClk or posedge csN or posedge linkRst) begin
        if (csN || linkRst) begin
            bitCount <= 4'h0;
            shiftReg <= 7'h00;
        end else begin
            if (counting) begin
                bitCount <= bitCount + 4'h1;
            end
            if (counting && !lastBit) begin
                shiftReg <= {shiftReg[5:0], si};
            end
        end
    end

    // ----------------------------------------
    // opcode capture on the eighth edge
    // ----------------------------------------
    always_ff @(posedge spiClk or posedge linkRst) begin
        if (linkRst) begin
            opcode <= 8'h00;
            opToggle <= 1'b0;
        end else if (!csN && lastBit) begin
            opcode <= {shiftReg, si};
            opToggle <= ~opToggle;
        end
    end

endmodule // sfd_link_rx
`default_nettype wire

// [design/sfd_opcode_decoder.sv]
// Purpose: decodes the first byte of each serial flash frame
// Assumes: addrLong comes from logic on sys_clk
// Notes: the opcode word crosses stable, announced by a toggle
`timescale 1ns/1ns
`default_nettype none
// How it works
// - 03h is the single-line read, address width per mode, at most 50 MHz.
// - 0Bh quick read per mode, 0Ch always four-byte; both up to 133 MHz.
// - 0Dh double-rate quick read per mode, 0Eh four-byte; at most 80 MHz.
// - 01h writes status and configuration together, up to 133 MHz.
// - 02h page write per mode, 12h page write with four-byte address.
// - 32h and 38h quad page write per mode, 34h four-byte; 80 MHz max.
// - 3Bh dual output read, 3Ch four-byte variant; 104 MHz max.
// - 6Bh quad output read, 6Ch four-byte variant; 104 MHz max.
// - BBh/BCh dual io read at 104 MHz; BDh/BEh double-rate at 80 MHz.
// - EBh/ECh quad io read at 104 MHz; EDh/EEh double-rate at 80 MHz.
// - D8h wipes a large sector per mode, DCh with four-byte address.
// - 20h wipes a 4 KB sector per mode, 21h with four-byte address.
// - 60h and C7h both wipe the whole array.
// - 30h clears the program and erase fail flags.
// - 9Fh returns identity data; ABh returns signature at 50 MHz max.
// - A3h held back, E5h and E6h reserved with no function.
// - 4Ah writes volatile learning pattern, 43h programs its stored copy.
// - 41h reads back the learning pattern, up to 133 MHz.
module sfd_opcode_decoder (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // link pins
    input wire logic spiClk,
    input wire logic csN,
    input wire logic si,
    // addressing mode, high for four-byte
    input wire logic addrLong,
    // decoded command
    output logic cmdValid,
    output logic cmdIgnored,
    output logic frameEnd,
    output logic frameActive,
    output sfd_pkg::sfd_cmd_info_s cmdInfo
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [2:0] addrWidth(input logic forceLong, input logic modeLong);
        addrWidth = (forceLong || modeLong) ? sfd_pkg::ADDR_LONG : sfd_pkg::ADDR_SHORT;
    endfunction

    function automatic sfd_pkg::sfd_cmd_info_s mk(
        input sfd_pkg::sfd_cmd_e cmd,
        input logic [7:0] op,
        input logic [2:0] aBytes,
        input logic [2:0] aLanes,
        input logic [3:0] dummy,
        input logic [2:0] dLanes,
        input logic dtr,
        input logic [7:0] mhz
    );
        mk.cmd = cmd;
        mk.opcode = op;
        mk.addrBytes = aBytes;
        mk.addrLanes = aLanes;
        mk.dummy = dummy;
        mk.dataLanes = dLanes;
        mk.dtr = dtr;
        mk.maxMhz = mhz;
    endfunction

    // other listed opcodes pass through with no decoded shape
    function automatic logic otherKnown(input logic [7:0] op);
        case (op)
            8'h04, 8'h05, 8'h06, 8'h07, 8'h14, 8'h15, 8'h16, 8'h17,
            8'h18, 8'h2B, 8'h2F, 8'h35, 8'h42, 8'h4B, 8'h75, 8'h7A,
            8'h85, 8'h8A, 8'h90, 8'hA6, 8'hA7, 8'hE0, 8'hE1, 8'hE2,
            8'hE3, 8'hE4, 8'hE7, 8'hE8, 8'hE9, 8'hF0: otherKnown = 1'b1;
            default: otherKnown = 1'b0;
        endcase
    endfunction

    function automatic sfd_pkg::sfd_cmd_info_s decode(input logic [7:0] op, input logic ml);
        logic [2:0] am;
        logic [2:0] al;
        am = addrWidth(1'b0, ml);
        al = addrWidth(1'b1, ml);
        case (op)
            sfd_pkg::OP_ARRAY_READ: decode = mk(sfd_pkg::SFD_CMD_READ, op, am,
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_ONE,
                1'b0, sfd_pkg::MHZ_SLOW);
            sfd_pkg::OP_ARRAY_READ_LONG: decode = mk(sfd_pkg::SFD_CMD_READ, op, al,
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_ONE,
                1'b0, sfd_pkg::MHZ_SLOW);
            sfd_pkg::OP_QUICK_READ, sfd_pkg::OP_QUICK_READ_LONG: decode = mk(
                sfd_pkg::SFD_CMD_QUICK_READ, op,
                addrWidth(op == sfd_pkg::OP_QUICK_READ_LONG, ml),
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_SDR, sfd_pkg::LANES_ONE,
                1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_DTR_QUICK_READ, sfd_pkg::OP_DTR_QUICK_READ_LONG: decode = mk(
                sfd_pkg::SFD_CMD_DTR_QUICK_READ, op,
                addrWidth(op == sfd_pkg::OP_DTR_QUICK_READ_LONG, ml),
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_DTR, sfd_pkg::LANES_ONE,
                1'b1, sfd_pkg::MHZ_DTR);
            sfd_pkg::OP_STATUS_CONFIG_WRITE: decode = mk(sfd_pkg::SFD_CMD_REG_WRITE,
                op, sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_PAGE_WRITE, sfd_pkg::OP_PAGE_WRITE_LONG: decode = mk(
                sfd_pkg::SFD_CMD_PAGE_WRITE, op,
                addrWidth(op == sfd_pkg::OP_PAGE_WRITE_LONG, ml),
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_ONE,
                1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_QUAD_PAGE_WRITE, sfd_pkg::OP_QUAD_PAGE_WRITE_ALT,
            sfd_pkg::OP_QUAD_PAGE_WRITE_LONG: decode = mk(
                sfd_pkg::SFD_CMD_QUAD_PAGE_WRITE, op,
                addrWidth(op == sfd_pkg::OP_QUAD_PAGE_WRITE_LONG, ml),
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_FOUR,
                1'b0, sfd_pkg::MHZ_DTR);
            sfd_pkg::OP_DUAL_OUT_READ, sfd_pkg::OP_DUAL_OUT_READ_LONG: decode = mk(
                sfd_pkg::SFD_CMD_DUAL_OUT_READ, op,
                addrWidth(op == sfd_pkg::OP_DUAL_OUT_READ_LONG, ml),
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_SDR, sfd_pkg::LANES_TWO,
                1'b0, sfd_pkg::MHZ_MULTI);
            sfd_pkg::OP_QUAD_OUT_READ, sfd_pkg::OP_QUAD_OUT_READ_LONG: decode = mk(
                sfd_pkg::SFD_CMD_QUAD_OUT_READ, op,
                addrWidth(op == sfd_pkg::OP_QUAD_OUT_READ_LONG, ml),
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_SDR, sfd_pkg::LANES_FOUR,
                1'b0, sfd_pkg::MHZ_MULTI);
            sfd_pkg::OP_DUAL_IO_READ, sfd_pkg::OP_DUAL_IO_READ_LONG: decode = mk(
                sfd_pkg::SFD_CMD_DUAL_IO_READ, op,
                addrWidth(op == sfd_pkg::OP_DUAL_IO_READ_LONG, ml),
                sfd_pkg::LANES_TWO, sfd_pkg::DUMMY_IO, sfd_pkg::LANES_TWO,
                1'b0, sfd_pkg::MHZ_MULTI);
            sfd_pkg::OP_DTR_DUAL_IO_READ, sfd_pkg::OP_DTR_DUAL_IO_READ_LONG: decode = mk(
                sfd_pkg::SFD_CMD_DTR_DUAL_IO_READ, op,
                addrWidth(op == sfd_pkg::OP_DTR_DUAL_IO_READ_LONG, ml),
                sfd_pkg::LANES_TWO, sfd_pkg::DUMMY_DTR, sfd_pkg::LANES_TWO,
                1'b1, sfd_pkg::MHZ_DTR);
            sfd_pkg::OP_QUAD_IO_READ, sfd_pkg::OP_QUAD_IO_READ_LONG: decode = mk(
                sfd_pkg::SFD_CMD_QUAD_IO_READ, op,
                addrWidth(op == sfd_pkg::OP_QUAD_IO_READ_LONG, ml),
                sfd_pkg::LANES_FOUR, sfd_pkg::DUMMY_IO, sfd_pkg::LANES_FOUR,
                1'b0, sfd_pkg::MHZ_MULTI);
            sfd_pkg::OP_DTR_QUAD_IO_READ, sfd_pkg::OP_DTR_QUAD_IO_READ_LONG: decode = mk(
                sfd_pkg::SFD_CMD_DTR_QUAD_IO_READ, op,
                addrWidth(op == sfd_pkg::OP_DTR_QUAD_IO_READ_LONG, ml),
                sfd_pkg::LANES_FOUR, sfd_pkg::DUMMY_DTR, sfd_pkg::LANES_FOUR,
                1'b1, sfd_pkg::MHZ_DTR);
            sfd_pkg::OP_BLOCK_WIPE, sfd_pkg::OP_BLOCK_WIPE_LONG: decode = mk(
                sfd_pkg::SFD_CMD_BLOCK_WIPE, op,
                addrWidth(op == sfd_pkg::OP_BLOCK_WIPE_LONG, ml),
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_ONE,
                1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_SMALL_WIPE, sfd_pkg::OP_SMALL_WIPE_LONG: decode = mk(
                sfd_pkg::SFD_CMD_SMALL_WIPE, op,
                addrWidth(op == sfd_pkg::OP_SMALL_WIPE_LONG, ml),
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_ONE,
                1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_WHOLE_WIPE, sfd_pkg::OP_WHOLE_WIPE_ALT: decode = mk(
                sfd_pkg::SFD_CMD_WHOLE_WIPE, op, sfd_pkg::ADDR_NONE,
                sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_ONE,
                1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_FAIL_CLEAR: decode = mk(sfd_pkg::SFD_CMD_FAIL_CLEAR, op,
                sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_IDENTITY_QUERY: decode = mk(sfd_pkg::SFD_CMD_IDENTITY, op,
                sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_SIGNATURE_QUERY: decode = mk(sfd_pkg::SFD_CMD_SIGNATURE, op,
                sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_SLOW);
            sfd_pkg::OP_BANK_ACCESS: decode = mk(sfd_pkg::SFD_CMD_BANK_ACCESS, op,
                sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_LEARN_VOLATILE_WRITE: decode = mk(sfd_pkg::SFD_CMD_LEARN_WRITE,
                op, sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_LEARN_NV_PROGRAM: decode = mk(sfd_pkg::SFD_CMD_LEARN_PROGRAM,
                op, sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_LEARN_READBACK: decode = mk(sfd_pkg::SFD_CMD_LEARN_READ, op,
                sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_FULL);
            sfd_pkg::OP_MODE_BITS_CLEAR: decode = mk(sfd_pkg::SFD_CMD_MODE_CLEAR, op,
                sfd_pkg::ADDR_NONE, sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE,
                sfd_pkg::LANES_ONE, 1'b0, sfd_pkg::MHZ_FULL);
            default: begin
                if (otherKnown(op)) begin
                    decode = mk(sfd_pkg::SFD_CMD_OTHER, op, sfd_pkg::ADDR_NONE,
                        sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_ONE,
                        1'b0, sfd_pkg::MHZ_FULL);
                end else begin
                    // held back and reserved codes fall here
                    decode = mk(sfd_pkg::SFD_CMD_NONE, op, sfd_pkg::ADDR_NONE,
                        sfd_pkg::LANES_ONE, sfd_pkg::DUMMY_NONE, sfd_pkg::LANES_ONE,
                        1'b0, 8'h00);
                end
            end
        endcase
    endfunction

    // ----------------------------------------
    // link side
    // ----------------------------------------
    logic linkRst;
    logic [7:0] linkOpcode;
    logic linkToggle;

    always_ff @(posedge sys_clk) begin
        linkRst <= srst;
    end

    sfd_link_rx u_link_rx (
        .spiClk(spiClk),
        .csN(csN),
        .si(si),
        .linkRst(linkRst),
        .opcode(linkOpcode),
        .opToggle(linkToggle)
    );

    // ----------------------------------------
    // crossings into sys_clk
    // ----------------------------------------
    logic csMeta;
    logic csSync;
    logic togMeta;
    logic togSync;
    logic togSeen;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            csMeta <= 1'b1;
            csSync <= 1'b1;
            togMeta <= 1'b0;
            togSync <= 1'b0;
            togSeen <= 1'b0;
        end else begin
            csMeta <= csN;
            csSync <= csMeta;
            togMeta <= linkToggle;
            togSync <= togMeta;
            togSeen <= togSync;
        end
    end

    // ----------------------------------------
    // decode and state
    // ----------------------------------------
    wire newOp = togSync ^ togSeen;
    wire csHigh = csSync;
    sfd_pkg::sfd_cmd_info_s decoded;
    assign decoded = decode(linkOpcode, addrLong);
    wire known = (decoded.cmd != sfd_pkg::SFD_CMD_NONE);

    sfd_pkg::sfd_state_e state;
    sfd_pkg::sfd_state_e next_state;
    logic next_valid;
    logic next_ignored;

    always_comb begin
        next_state = state;
        next_valid = 1'b0;
        next_ignored = 1'b0;
        case (state)
            sfd_pkg::SFD_ST_IDLE, sfd_pkg::SFD_ST_WAIT_OP: begin
                if (newOp) begin
                    next_valid = known;
                    next_ignored = !known;
                    next_state = known ? sfd_pkg::SFD_ST_ACTIVE : sfd_pkg::SFD_ST_SKIP;
                end else if (!csHigh) begin
                    next_state = sfd_pkg::SFD_ST_WAIT_OP;
                end else begin
                    next_state = sfd_pkg::SFD_ST_IDLE;
                end
            end
            sfd_pkg::SFD_ST_ACTIVE, sfd_pkg::SFD_ST_SKIP: begin
                if (csHigh) begin
                    next_state = sfd_pkg::SFD_ST_IDLE;
                end
            end
            default: next_state = sfd_pkg::SFD_ST_IDLE;
        endcase
    end

    wire leaving = csHigh && (state == sfd_pkg::SFD_ST_ACTIVE
        || state == sfd_pkg::SFD_ST_SKIP);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= sfd_pkg::SFD_ST_IDLE;
            cmdValid <= 1'b0;
            cmdIgnored <= 1'b0;
            frameEnd <= 1'b0;
            frameActive <= 1'b0;
            cmdInfo <= '0;
        end else begin
            state <= next_state;
            cmdValid <= next_valid;
            cmdIgnored <= next_ignored;
            frameEnd <= leaving;
            frameActive <= !csHigh;
            if (next_valid) begin
                cmdInfo <= decoded;
            end
        end
    end

endmodule // sfd_opcode_decoder
`default_nettype wire

// [dv/sfd_opcode_decoder_assertions.sv]
// Purpose: port checks of the opcode decoder
// Assumes: addrLong steady through each frame
// Notes: bound to the decoder top
`timescale 1ns/1ns
`default_nettype none
module sfd_opcode_decoder_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // mode and results
    input wire logic addrLong,
    input wire logic cmdValid,
    input wire logic cmdIgnored,
    input wire logic frameActive,
    input wire sfd_pkg::sfd_cmd_info_s cmdInfo
);
    wire logic [7:0] op = cmdInfo.opcode;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_excl; !(cmdValid && cmdIgnored); endproperty
    a_excl: assert property (p_excl) else $error("valid with ignored");
    property p_hold; cmdIgnored |-> cmdInfo == $past(cmdInfo); endproperty
    a_hold: assert property (p_hold) else $error("ignored op changed info");
    property p_pulse; cmdValid |=> !cmdValid; endproperty
    a_pulse: assert property (p_pulse) else $error("valid held");
    property p_act; (cmdValid || cmdIgnored) |-> frameActive; endproperty
    a_act: assert property (p_act) else $error("answer outside frame");
    property p_slow; cmdValid && op inside {8'h03, 8'h13, 8'hAB} |-> cmdInfo.maxMhz == 8'h32;
    endproperty
    a_slow: assert property (p_slow) else $error("slow limit");
    property p_long; cmdValid && op inside {8'h0C, 8'h12, 8'h21, 8'h3C, 8'hDC, 8'hEC}
        |-> cmdInfo.addrBytes == sfd_pkg::ADDR_LONG; endproperty
    a_long: assert property (p_long) else $error("forced long address");
    property p_mode; cmdValid && op inside {8'h02, 8'h0B, 8'h20, 8'hD8}
        |-> cmdInfo.addrBytes == (addrLong ? 3'h4 : 3'h3); endproperty
    a_mode: assert property (p_mode) else $error("mode address width");
    property p_dtr; cmdValid && op inside {8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE}
        |-> cmdInfo.dtr && cmdInfo.maxMhz == 8'h50; endproperty
    a_dtr: assert property (p_dtr) else $error("double rate");
    property p_wipe; cmdValid && op inside {8'h60, 8'hC7}
        |-> cmdInfo.cmd == sfd_pkg::SFD_CMD_WHOLE_WIPE; endproperty
    a_wipe: assert property (p_wipe) else $error("whole wipe");
    property p_resv; cmdValid |-> !(op inside {8'hA3, 8'hE5, 8'hE6}); endproperty
    a_resv: assert property (p_resv) else $error("reserved decoded");
endmodule // sfd_opcode_decoder_assertions
bind sfd_opcode_decoder sfd_opcode_decoder_assertions chk_i (.sys_clk, .srst, .addrLong,
    .cmdValid, .cmdIgnored, .frameActive, .cmdInfo);
`default_nettype wire

// [dv/sfd_spi_host.sv]
// Purpose: host side of the serial link
// Assumes: mode 0, clock still between frames
// Notes: data line shows inverse of last bit when released
`timescale 1ns/1ns
`default_nettype none
module sfd_spi_host (
    // link pins
    output logic spiClk,
    output logic csN,
    output logic si
);
    initial begin
        spiClk = 1'b0;
        csN = 1'b1;
        si = 1'b1;
    end
    // one frame of n bits, msb first, 64 ns clock
    task automatic send(input logic [7:0] b, input int n);
        csN = 1'b0;
        for (int k = 7; k > 7 - n; k--) begin
            si = b[k];
            #32 spiClk = 1'b1;
            #32 spiClk = 1'b0;
        end
        #32 csN = 1'b1;
        si = ~si;
    endtask
endmodule // sfd_spi_host
`default_nettype wire

// [dv/testbench.sv]
// Purpose: self checking bench of the opcode decoder
// Assumes: host model drives the link
// Notes: table, refused and random frames
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    logic sys_clk, srst, addrLong, spiClk, csN, si, cmdValid, cmdIgnored, frameEnd, frameActive;
    sfd_pkg::sfd_cmd_info_s cmdInfo;
    int mismatches = 0, checked = 0, cyc = 0;
    logic [31:0] rng = 32'hD00D;
    // refused codes, then the table with write enable first, mode clear last
    logic [7:0] bad[$] = '{8'hA3, 8'hE5, 8'hE6, 8'h00, 8'h55};
    logic [7:0] ops[$] = '{8'h06, 8'h01, 8'h02, 8'h03, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h12, 8'h13,
        8'h20, 8'h21, 8'h30, 8'h32, 8'h34, 8'h38, 8'h3B, 8'h3C, 8'h41, 8'h43, 8'h4A, 8'h60,
        8'h6B, 8'h6C, 8'h9F, 8'hAB, 8'hB9, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hC7, 8'hD8, 8'hDC,
        8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hFF};
    sfd_spi_host sfd_spi_host_i (.spiClk, .csN, .si);
    sfd_opcode_decoder sfd_opcode_decoder_i (.sys_clk, .srst, .spiClk, .csN, .si, .addrLong,
        .cmdValid, .cmdIgnored, .frameEnd, .frameActive, .cmdInfo);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic int mhz(input logic [7:0] o);
        if (o inside {8'h03, 8'h13, 8'hAB}) return 50;
        if (o inside {8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE, 8'h32, 8'h34, 8'h38}) return 80;
        if (o inside {8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC}) return 104;
        return 133;
    endfunction
    function automatic int abytes(input logic [7:0] o, input logic lng);
        if (o inside {8'h0C, 8'h0E, 8'h12, 8'h13, 8'h21, 8'h34, 8'h3C, 8'h6C, 8'hBC, 8'hBE, 8'hEC,
            8'hEE, 8'hDC}) return 4;
        if (o inside {8'h02, 8'h03, 8'h0B, 8'h0D, 8'h20, 8'h32, 8'h38, 8'h3B, 8'h6B, 8'hBB,
            8'hBD, 8'hEB, 8'hED, 8'hD8}) return lng ? 4 : 3;
        return -1;
    endfunction
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic frame(input logic [7:0] o, input int n, input logic lng);
        int v, g, a, fe;
        logic bd;
        v = 0;
        g = 0;
        fe = 0;
        bd = o inside {8'hA3, 8'hE5, 8'hE6, 8'h00, 8'h55};
        a = abytes(o, lng);
        @(negedge sys_clk) addrLong = lng;
        sfd_spi_host_i.send(o, n);
        repeat (20) begin
            @(posedge sys_clk);
            #1;
            if (cmdIgnored === 1'b1) g++;
            if (frameEnd === 1'b1) fe++;
            if (cmdValid === 1'b1) begin
                v++;
                `CHK("opcode", o, cmdInfo.opcode)
                `CHK("maxMhz", 8'(mhz(o)), cmdInfo.maxMhz)
                if (a >= 0) `CHK("addrBytes", 3'(a), cmdInfo.addrBytes)
            end
        end
        `CHK("answers", (n == 8) ? 1 : 0, v + g)
        `CHK("cmdValid", (n == 8 && !bd) ? 1 : 0, v)
        `CHK("cmdIgnored", (n == 8 && bd) ? 1 : 0, g)
        `CHK("frameEnd", (n == 8) ? 1 : 0, fe)
        `CHK("frameActive", 1'b0, frameActive)
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        srst = 1'b1;
        addrLong = 1'b0;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk) srst = 1'b0;
        repeat (4) @(posedge sys_clk);
        foreach (ops[k]) for (int m = 0; m < 2; m++) frame(ops[k], 8, m[0]);
        $display("table test done");
        foreach (bad[k]) frame(bad[k], 8, k[0]);
        frame(8'h03, 5, 1'b1);
        $display("refused test done");
        repeat (40) begin
            rng = xorshift(rng);
            frame(ops[rng % ops.size()], 8, rng[8]);
        end
        $display("random test done");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
